// ---- blk_pkg.sv ----
// constants and types shared by the block transfer issuer and memory path
// Contract
// - barrier or trap before state-register change after store
// - block load unordered against stores, no hazards
// - page side-effect attribute ignored for block accesses
// - store-to-load barrier orders load after stores
// - load-to-store barrier orders load before stores
// - trap drains all pending block loads
// - unfenced overlap may return old or new data
// - block store unordered, no hazard detection
// - trap drains all pending block stores
// - barrier between earlier load and overlapping store
// - trap or barrier before later overlapping load
// - trap or full barrier before later store/flush
// - full barrier orders two successive block stores
// - block operations always run relaxed ordering
// - no dependence checks between block operations
// - watchpoints match only first eight bytes
// - address low six bits nonzero raises misalignment
// - register number not multiple of eight illegal
// - no allocate on miss, update second level on hit
// - one load and fifteen stores outstanding
`default_nettype none
package blk_pkg;
    localparam int ADDR_W        = 44;
    localparam int DATA_W        = 64;
    localparam int FREG_W        = 6;
    localparam int BLOCK_LSB     = 6;              // 64-byte block
    localparam int FREG_ALIGN    = 3;              // groups of eight doubles
    localparam int WATCH_LSB     = 3;              // first eight bytes only
    localparam int MAX_LD_OUT    = 1;
    localparam int MAX_ST_OUT    = 15;
    localparam int OUT_CNT_W     = 4;
    localparam int BEATS         = 8;
    localparam logic [2:0] BEAT_LAST = 3'h7;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_LOAD  = 3'b001,
        OP_STORE = 3'b010,
        OP_SYNC  = 3'b011,   // full synchronising barrier
        OP_SL    = 3'b100,   // store-to-load barrier
        OP_LS    = 3'b101,   // load-to-store barrier
        OP_TRAP  = 3'b110
    } op_t;

    typedef enum logic [2:0] {
        EXC_NONE     = 3'b000,
        EXC_FP_DIS   = 3'b001,
        EXC_ILL      = 3'b010,
        EXC_MISALIGN = 3'b011,
        EXC_ACC_ERR  = 3'b100,
        EXC_MMU_MISS = 3'b101,
        EXC_PROT     = 3'b110,
        EXC_WATCH    = 3'b111
    } exc_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SEND  = 2'b01,
        ST_DRAIN = 2'b10
    } st_t;
endpackage : blk_pkg
`default_nettype wire

// ---- blk_if.sv ----
// link between the instruction-stream issuer and the memory path
`default_nettype none
interface blk_if (
    input wire logic clk,
    input wire logic rstn
);
    import blk_pkg::*;
    op_t                 req_op;
    logic                req_valid;
    logic                req_ready;
    logic [ADDR_W-1:0]   req_addr;
    logic [FREG_W-1:0]   req_freg;
    logic                req_side_effect;
    logic [DATA_W-1:0]   wdata;
    logic                wvalid;
    logic                wready;
    logic [DATA_W-1:0]   rdata;
    logic                rvalid;
    logic                rready;
    logic                done;
    exc_t                exc;
    logic                idle;

    modport mem (
        input  req_op, req_valid, req_addr, req_freg, req_side_effect,
        input  wdata, wvalid, rready,
        output req_ready, wready, rdata, rvalid, done, exc, idle
    );
    modport issuer (
        output req_op, req_valid, req_addr, req_freg, req_side_effect,
        output wdata, wvalid, rready,
        input  req_ready, wready, rdata, rvalid, done, exc, idle
    );
endinterface : blk_if
`default_nettype wire

// ---- blk_mem_path.sv ----
// memory-path end: checks, watchpoint, outstanding counts, read buffer
`default_nettype none
module blk_mem_path (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    blk_if.mem                            bus,
    input  wire logic                     fp_enabled,
    input  wire logic                     watch_en,
    input  wire logic [blk_pkg::ADDR_W-1:0] watch_addr,
    input  wire logic                     tlb_miss,
    input  wire logic                     prot_fault,
    input  wire logic                     acc_error,
    input  wire logic                     l2_hit,
    output logic                          l2_update,
    output logic                          fill_alloc,
    output logic                          mem_ld_issue,
    output logic                          mem_st_issue,
    input  wire logic                     mem_st_ack,
    input  wire logic                     mem_rvalid,
    input  wire logic [blk_pkg::DATA_W-1:0] mem_rdata,
    output logic                          mem_rready
);
    import blk_pkg::*;

    logic [OUT_CNT_W-1:0] st_out_reg;
    logic                 ld_out_reg;
    logic [2:0]           beat_reg;
    logic [DATA_W-1:0]    buf_mem [2];
    logic                 wp_reg, rp_reg;
    logic [1:0]           cnt_reg;
    exc_t                 exc_next;
    logic                 take, st_accept, st_done, drain;
    logic                 fresh, ld_accept;

    // classify exceptions in precise priority order
    always_comb begin
        exc_next = EXC_NONE;
        if (!fp_enabled)                                    exc_next = EXC_FP_DIS;
        else if (bus.req_freg[FREG_ALIGN-1:0] != 3'h0)      exc_next = EXC_ILL;
        else if (bus.req_addr[BLOCK_LSB-1:0] != 6'h00)      exc_next = EXC_MISALIGN;
        else if (watch_en &&
                 bus.req_addr[ADDR_W-1:WATCH_LSB] == watch_addr[ADDR_W-1:WATCH_LSB])
            exc_next = EXC_WATCH;
        else if (tlb_miss)                                  exc_next = EXC_MMU_MISS;
        else if (prot_fault)                                exc_next = EXC_PROT;
        else if (acc_error)                                 exc_next = EXC_ACC_ERR;
    end

    // barriers and traps wait for drain; loads and stores never check addresses
    assign drain = (st_out_reg == '0) && !ld_out_reg;
    always_comb begin
        case (bus.req_op)
            OP_LOAD:  take = !ld_out_reg && (MAX_LD_OUT == 1);
            OP_STORE: take = (st_out_reg < OUT_CNT_W'(MAX_ST_OUT)) && beat_reg == 3'h0;
            OP_SYNC, OP_SL, OP_LS, OP_TRAP: take = drain;
            default:  take = 1'b1;
        endcase
    end
    // a request still high in its done cycle is the same request, never a second one
    assign fresh     = bus.req_valid && !bus.done;
    assign st_accept = fresh && take && bus.req_op == OP_STORE && exc_next == EXC_NONE;
    assign ld_accept = fresh && take && bus.req_op == OP_LOAD && exc_next == EXC_NONE;
    assign st_done   = mem_st_ack && st_out_reg != '0;

    // request answer: done pulse with exception code, side-effect ignored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.done      <= 1'b0;
            bus.exc       <= EXC_NONE;
            bus.req_ready <= 1'b0;
            mem_ld_issue  <= 1'b0;
            mem_st_issue  <= 1'b0;
            l2_update     <= 1'b0;
            fill_alloc    <= 1'b0;
        end else begin
            bus.req_ready <= take;
            bus.done      <= fresh && take;
            bus.exc       <= (fresh && take &&
                              (bus.req_op == OP_LOAD || bus.req_op == OP_STORE)) ?
                             exc_next : EXC_NONE;
            mem_ld_issue  <= ld_accept;
            mem_st_issue  <= st_accept;
            l2_update     <= st_accept && l2_hit;
            fill_alloc    <= 1'b0;
        end
    end

    // outstanding counters
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_out_reg <= '0;
            ld_out_reg <= 1'b0;
        end else begin
            st_out_reg <= st_out_reg + OUT_CNT_W'(st_accept) - OUT_CNT_W'(st_done);
            if (ld_accept)
                ld_out_reg <= 1'b1;
            else if (mem_rvalid && mem_rready && beat_reg == BEAT_LAST)
                ld_out_reg <= 1'b0;
        end
    end

    // store beats accepted in every cycle after reset, whether or not a store is taken
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) bus.wready <= 1'b0;
        else       bus.wready <= 1'b1;
    end

    // two-entry read buffer: a stalled issuer loses no beat
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
            beat_reg <= 3'h0;
            mem_rready <= 1'b0;
            bus.rvalid <= 1'b0;
            bus.rdata <= '0;
        end else begin
            logic push, pop;
            push = mem_rvalid && mem_rready;
            pop  = bus.rvalid && bus.rready;
            if (push) begin
                buf_mem[wp_reg] <= mem_rdata;
                wp_reg <= ~wp_reg;
                beat_reg <= beat_reg + 3'h1;
            end
            if (pop) rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
            mem_rready <= (cnt_reg + 2'(push) - 2'(pop)) < 2'h1 ||
                          ((cnt_reg + 2'(push) - 2'(pop)) == 2'h1 && !push);
            bus.rvalid <= (cnt_reg + 2'(push) - 2'(pop)) != 2'h0;
            bus.rdata  <= (cnt_reg == 2'h0 || (pop && cnt_reg == 2'h1)) ? mem_rdata :
                          (pop ? buf_mem[~rp_reg] : buf_mem[rp_reg]);
        end
    end

    // idle flag read by the checks and the bench; the issuer does not use it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) bus.idle <= 1'b1;
        else       bus.idle <= drain && !st_accept && !ld_accept;
    end
endmodule : blk_mem_path
`default_nettype wire

// ---- blk_issuer.sv ----
// issuer end: sends requests and places barriers the ordering calls for
`default_nettype none
module blk_issuer (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    blk_if.issuer                            bus,
    input  wire blk_pkg::op_t                cmd_op,
    input  wire logic                        cmd_valid,
    input  wire logic [blk_pkg::ADDR_W-1:0]  cmd_addr,
    input  wire logic [blk_pkg::FREG_W-1:0]  cmd_freg,
    input  wire logic                        cmd_side_effect,
    input  wire logic                        cmd_state_write,
    output logic                             cmd_ready,
    output logic                             cmd_done,
    output blk_pkg::exc_t                    cmd_exc,
    output logic [blk_pkg::DATA_W-1:0]       load_data,
    output logic                             load_valid,
    input  wire logic                        load_ready,
    input  wire logic [blk_pkg::DATA_W-1:0]  store_data
);
    import blk_pkg::*;

    op_t  last_reg;
    logic busy_reg;
    logic fence_reg;   // request in flight is an inserted barrier, not the command

    // pop a read beat only when the output stage can take it
    assign bus.rready = !load_valid || load_ready;

    // before a state write following a store, insert a full barrier
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.req_valid <= 1'b0;
            bus.req_op <= OP_NONE;
            bus.req_addr <= '0;
            bus.req_freg <= '0;
            bus.req_side_effect <= 1'b0;
            busy_reg <= 1'b0;
            fence_reg <= 1'b0;
            last_reg <= OP_NONE;
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= 1'b0;
            if (busy_reg) begin
                if (bus.done) begin
                    bus.req_valid <= 1'b0;
                    busy_reg <= 1'b0;
                end
            end else if (cmd_valid && !cmd_ready) begin
                busy_reg <= 1'b1;
                bus.req_valid <= 1'b1;
                bus.req_addr <= cmd_addr;
                bus.req_freg <= cmd_freg;
                bus.req_side_effect <= cmd_side_effect;
                if ((cmd_state_write && last_reg == OP_STORE) ||
                    (cmd_op == OP_STORE && last_reg == OP_STORE) ||
                    (cmd_op == OP_LOAD && last_reg == OP_STORE)) begin
                    bus.req_op <= OP_SYNC;
                    last_reg <= OP_SYNC;
                    fence_reg <= 1'b1;
                end else if (cmd_op == OP_STORE && last_reg == OP_LOAD) begin
                    bus.req_op <= OP_LS;
                    last_reg <= OP_LS;
                    fence_reg <= 1'b1;
                end else begin
                    bus.req_op <= cmd_op;
                    fence_reg <= 1'b0;
                    // partial barriers do not order two stores, keep the hazard
                    if (cmd_op != OP_SL && cmd_op != OP_LS)
                        last_reg <= cmd_op;
                    cmd_ready <= 1'b1;
                end
            end
        end
    end

    // answer and data paths
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_done <= 1'b0;
            cmd_exc <= EXC_NONE;
            load_data <= '0;
            load_valid <= 1'b0;
            bus.wvalid <= 1'b0;
            bus.wdata <= '0;
        end else begin
            cmd_done <= bus.done && busy_reg && !fence_reg;
            cmd_exc <= bus.exc;
            if (!load_valid || load_ready) begin
                load_valid <= bus.rvalid && bus.rready;
                load_data <= bus.rdata;
            end
            bus.wvalid <= bus.req_valid && bus.req_op == OP_STORE;
            bus.wdata <= store_data;
        end
    end
endmodule : blk_issuer
`default_nettype wire

// ---- blk_sva.sv ----
// concurrent checks on the link between issuer and memory path
`default_nettype none
module blk_sva (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire blk_pkg::op_t           req_op,
    input wire logic                   req_valid,
    input wire logic [blk_pkg::ADDR_W-1:0] req_addr,
    input wire logic [blk_pkg::FREG_W-1:0] req_freg,
    input wire logic [blk_pkg::DATA_W-1:0] rdata,
    input wire logic                   rvalid,
    input wire logic                   rready,
    input wire logic                   done,
    input wire blk_pkg::exc_t          exc,
    input wire logic                   idle
);
    import blk_pkg::*;
    op_t cur_reg;
    op_t last_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // last op that finished cleanly; a refused op forgets history to stay permissive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg  <= OP_NONE;
            last_reg <= OP_NONE;
        end else begin
            if (req_valid) cur_reg <= req_op;
            if (done) last_reg <= (exc == EXC_NONE) ? cur_reg : OP_NONE;
        end
    end

    sequence s_blk_done;
        done && ($past(req_op) == OP_LOAD || $past(req_op) == OP_STORE);
    endsequence
    sequence s_fence_done;
        done && ($past(req_op) == OP_SYNC || $past(req_op) == OP_TRAP);
    endsequence

    AST_DONE_CAUSE: assert property (done |-> $past(req_valid))
        else $error("done without a request");
    AST_EXC_WITH_DONE: assert property (exc != EXC_NONE |-> done)
        else $error("exception outside done");
    AST_MISALIGN: assert property (s_blk_done ##0 $past(req_addr[5:0]) != 6'h0
        ##0 $past(req_freg[2:0]) == 3'h0 |-> exc inside {EXC_FP_DIS, EXC_MISALIGN})
        else $error("misaligned block not refused");
    AST_ILL_FREG: assert property (s_blk_done ##0 $past(req_freg[2:0]) != 3'h0
        |-> exc inside {EXC_FP_DIS, EXC_ILL})
        else $error("unaligned register group not refused");
    AST_ALIGNED_OK: assert property (s_blk_done ##0 $past(req_addr[5:0]) == 6'h0
        ##0 $past(req_freg[2:0]) == 3'h0 |-> !(exc inside {EXC_ILL, EXC_MISALIGN}))
        else $error("aligned block refused");
    AST_FENCE_DRAIN: assert property (s_fence_done |-> idle)
        else $error("fence done with work outstanding");
    AST_PROMPT_TAKE: assert property (req_valid && idle && !done |=> done)
        else $error("request stalled with nothing outstanding");
    AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read beat dropped under stall");
    AST_ST_FENCED: assert property (req_valid && req_op == OP_STORE
        |-> !(last_reg inside {OP_STORE, OP_LOAD}))
        else $error("store without barrier");
    AST_LD_FENCED: assert property (req_valid && req_op == OP_LOAD
        |-> last_reg != OP_STORE)
        else $error("load after store without barrier");
endmodule : blk_sva
`default_nettype wire

// ---- tb_block_transfer_ordering.sv ----
// self-checking bench for the issuer and memory path pair
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp=%0h got=%0h", n, e, g); end end
module tb_block_transfer_ordering;
    import blk_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, fp_en, w_en, tlb, prot, acc, l2h, l2u, fill, mld, mst, m_rr;
    logic c_v, c_se, c_sw, c_rdy, c_dn, ld_v, ld_rdy;
    logic              st_ack = 1'b0;
    logic              m_rv   = 1'b0;
    logic              hs     = 1'b0;
    logic [31:0]       seed   = 32'h67588b12;
    logic [ADDR_W-1:0] w_a, c_a;
    logic [DATA_W-1:0] m_rd, ld_d, st_d;
    logic [FREG_W-1:0] c_f;
    op_t               c_op;
    exc_t              c_exc;
    int                pend = 0, bi = 8, got = 0, nld = 0, nl2 = 0, nl2e = 0;
    int                n_fail = 0, compares = 0;

    blk_if blk_if_inst (.clk(clk), .rstn(rstn));
    blk_mem_path blk_mem_path_inst (.clk(clk), .rstn(rstn), .bus(blk_if_inst.mem),
        .fp_enabled(fp_en), .watch_en(w_en), .watch_addr(w_a), .tlb_miss(tlb),
        .prot_fault(prot), .acc_error(acc), .l2_hit(l2h), .l2_update(l2u), .fill_alloc(fill),
        .mem_ld_issue(mld), .mem_st_issue(mst), .mem_st_ack(st_ack), .mem_rvalid(m_rv),
        .mem_rdata(m_rd), .mem_rready(m_rr));
    blk_issuer blk_issuer_inst (.clk(clk), .rstn(rstn), .bus(blk_if_inst.issuer),
        .cmd_op(c_op), .cmd_valid(c_v), .cmd_addr(c_a), .cmd_freg(c_f),
        .cmd_side_effect(c_se), .cmd_state_write(c_sw), .cmd_ready(c_rdy), .cmd_done(c_dn),
        .cmd_exc(c_exc), .load_data(ld_d), .load_valid(ld_v), .load_ready(ld_rdy),
        .store_data(st_d));
    blk_sva blk_sva_inst (.clk(clk), .rstn(rstn), .req_op(blk_if_inst.req_op),
        .req_valid(blk_if_inst.req_valid), .req_addr(blk_if_inst.req_addr),
        .req_freg(blk_if_inst.req_freg), .rdata(blk_if_inst.rdata),
        .rvalid(blk_if_inst.rvalid), .rready(blk_if_inst.rready), .done(blk_if_inst.done),
        .exc(blk_if_inst.exc), .idle(blk_if_inst.idle));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nxt

    // beat pattern the memory returns, so order errors show up
    function automatic logic [63:0] pat(input int i);
        return {32'h9e3779b9, 24'h0, i[7:0]};
    endfunction : pat

    // exception the command should end with, highest priority first
    function automatic exc_t exp_exc(input op_t op, input logic [43:0] a, input logic [5:0] f);
        if (op != OP_LOAD && op != OP_STORE) return EXC_NONE;
        if (!fp_en) return EXC_FP_DIS;
        if (f[2:0] != 3'h0) return EXC_ILL;
        if (a[5:0] != 6'h0) return EXC_MISALIGN;
        if (w_en && a[43:3] == w_a[43:3]) return EXC_WATCH;
        if (tlb) return EXC_MMU_MISS;
        if (prot) return EXC_PROT;
        if (acc) return EXC_ACC_ERR;
        return EXC_NONE;
    endfunction : exp_exc

    // memory side: random store acks, eight read beats, random stall by the consumer
    always @(posedge clk) hs <= m_rv && m_rr;
    always @(negedge clk) begin
        if (st_ack) pend--;
        if (mst) pend++;
        if (mld) bi = 0;
        else if (hs) bi++;
        st_ack = pend > 0 && seed[0];
        m_rv = bi < 8;
        m_rd = m_rv ? pat(bi) : ~m_rd;
        ld_rdy = seed[1] | seed[2];
        st_d = {nxt(), nxt()};
    end
    always @(posedge clk) begin
        if (ld_v && ld_rdy) begin
            `CHK("load beat", pat(got % 8), ld_d)
            got++;
        end
        if (rstn) `CHK("fill alloc", 1'b0, fill)
        if (l2u) nl2++;
    end

    task automatic run(input op_t op, input logic [43:0] a, input logic [5:0] f);
        logic rs;
        logic dn;
        exc_t e;
        e = exp_exc(op, a, f);
        rs = 1'b0;
        dn = 1'b0;
        c_op = op;
        c_a = a;
        c_f = f;
        c_se = seed[3];
        c_v = 1'b1;
        repeat (300) begin
            @(posedge clk);
            if (c_rdy) rs = 1'b1;
            dn = c_dn;
            if (dn) break;
            @(negedge clk);
            if (rs) c_v = 1'b0;
        end
        `CHK("cmd done", 1'b1, dn)
        `CHK("exc", e, c_exc)
        if (op == OP_TRAP) `CHK("idle after trap", 1'b1, blk_if_inst.idle)
        if (op == OP_LOAD && e == EXC_NONE) nld++;
        if (op == OP_STORE && e == EXC_NONE && l2h) nl2e++;
        @(negedge clk);
        c_v = 1'b0;
    endtask : run

    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    initial begin
        logic [31:0] r;
        {fp_en, w_en, tlb, prot, acc, l2h, c_v, c_se, c_sw, ld_rdy} = 10'h200;
        {w_a, c_a, c_f, st_d, m_rd} = '0;
        c_op = OP_NONE;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (2) @(negedge clk);
        // one hand-made case per exception, watch on second doubleword must stay silent
        for (int k = 0; k < 9; k++) begin
            {fp_en, tlb, prot, acc, w_en} = {k != 1, k == 6, k == 7, k == 8, k == 4 || k == 5};
            w_a = 44'h123456789c0 + ((k == 5) ? 44'h8 : 44'h4);
            run((k % 2) ? OP_STORE : OP_LOAD, 44'h123456789c0 | ((k == 3) ? 44'h20 : 44'h0),
                (k == 2) ? 6'h3 : 6'h8);
        end
        // random stream of block ops, barriers and traps, mostly legal
        repeat (60) begin
            r = nxt();
            {fp_en, tlb, prot, acc} = {r[7:4] != 0, r[11:8] == 0, r[15:12] == 0, r[19:16] == 0};
            {l2h, w_en, c_sw} = r[22:20];
            w_a = {r, 12'h0};
            run(op_t'(3'(1 + r[25:23] % 6)), {12'h0, nxt() & (r[26] ? 32'hffffffff : ~32'h3f)},
                r[27] ? 6'(nxt()) : {r[30:28], 3'h0});
        end
        run(OP_TRAP, '0, '0);
        repeat (50) @(posedge clk);
        `CHK("load beats", nld * 8, got)
        `CHK("l2 updates", nl2e, nl2)
        complete_run();
    end

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #(50 * 20000);
        n_fail++;
        complete_run();
    end
endmodule : tb_block_transfer_ordering
`undef CHK
`default_nettype wire
